//--- flash_status_defines.svh
// Constants for the flash status polling controller
// Overview of operation
// - Host masks reserved status bits 0, 1, 4
// - Host polls programmed address or erased block
// - Two reads with equal bit 6 mean operation finished
// - Error bit held until read/reset command
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH

`define DQ_POLL_BIT       7
`define DQ_TOGGLE_BIT     6
`define DQ_ERROR_BIT      5
`define DQ_ETIMER_BIT     3
`define DQ_TOGGLE2_BIT    2
`define STATUS_MASK       8'hec

`define CLK_PERIOD_NS     20
`define ACCESS_NS         120
`define ACCESS_CYCLES     ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS    60
`define WRITE_CYCLES      ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_TIMER_MAX_US 120
`define ERASE_TIMER_CYCLES ((`ERASE_TIMER_MAX_US * 1000) / `CLK_PERIOD_NS)
`define POLL_LIMIT_DEFAULT 65535

`endif

//--- flash_status_pkg.sv
// Types for the flash status polling controller
package flash_status_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_TIMER_READ,
    ST_READ_A,
    ST_READ_B,
    ST_ERR_A,
    ST_ERR_B,
    ST_FINAL,
    ST_RESET_CMD,
    ST_DONE
  } poll_state_t;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_STROBE,
    CYC_RECOVER
  } cycle_state_t;

endpackage

//--- flash_bus_cycle.sv
// One asynchronous flash bus cycle, read or write
`timescale 1ns/1ps
`include "flash_status_defines.svh"
module flash_bus_cycle
  import flash_status_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Request from the poller
  input  wire logic              req,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   ack,
  output logic [DATA_W-1:0]      rdata,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_chip_select_n,
  output logic                   flash_output_enable_n,
  output logic                   flash_write_strobe_n
);

  localparam logic [3:0] READ_LEN  = 4'(`ACCESS_CYCLES);
  localparam logic [3:0] WRITE_LEN = 4'(`WRITE_CYCLES);

  cycle_state_t     state_reg;
  logic [3:0]       cnt_reg;
  logic             is_write_reg;

  wire logic        strobe_end = (cnt_reg == 4'h1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg             <= CYC_IDLE;
      cnt_reg               <= 4'h0;
      is_write_reg          <= 1'b0;
      ack                   <= 1'b0;
      rdata                 <= '0;
      flash_addr            <= '0;
      flash_dq_out          <= '0;
      flash_dq_oe           <= 1'b0;
      flash_chip_select_n   <= 1'b1;
      flash_output_enable_n <= 1'b1;
      flash_write_strobe_n  <= 1'b1;
    end else begin
      ack <= 1'b0;
      case (state_reg)
        CYC_IDLE: begin
          if (req) begin
            is_write_reg          <= req_write;
            flash_addr            <= req_addr;
            flash_dq_out          <= req_wdata;
            flash_dq_oe           <= req_write;
            flash_chip_select_n   <= 1'b0;
            flash_output_enable_n <= req_write;
            flash_write_strobe_n  <= ~req_write;
            cnt_reg               <= req_write ? WRITE_LEN : READ_LEN;
            state_reg             <= CYC_STROBE;
          end
        end
        CYC_STROBE: begin
          if (strobe_end) begin
            // Select and enable both rise so every read is a fresh toggle event
            if (!is_write_reg) begin
              rdata <= flash_dq_in;
            end
            flash_chip_select_n   <= 1'b1;
            flash_output_enable_n <= 1'b1;
            flash_write_strobe_n  <= 1'b1;
            state_reg             <= CYC_RECOVER;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        CYC_RECOVER: begin
          // Write data held one cycle past the strobe rise
          flash_dq_oe <= 1'b0;
          ack         <= 1'b1;
          state_reg   <= CYC_IDLE;
        end
        default: begin
          state_reg <= CYC_IDLE;
        end
      endcase
    end
  end

endmodule

//--- flash_program_erase_status.sv
// Host side poller of flash program and erase status
`timescale 1ns/1ps
`include "flash_status_defines.svh"
module flash_program_erase_status
  import flash_status_pkg::*;
#(
  parameter int              ADDR_W             = 21,
  parameter int              DATA_W             = 16,
  parameter int              ERASE_TIMER_CYCLES = `ERASE_TIMER_CYCLES,
  parameter int              POLL_LIMIT         = `POLL_LIMIT_DEFAULT,
  parameter logic [15:0]     READ_RESET_DATA    = 16'h00f0
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // User command port
  input  wire logic              start,
  input  wire logic              op_is_erase,
  input  wire logic [ADDR_W-1:0] poll_addr,
  input  wire logic              expected_dq7,
  output logic                   busy,
  output logic                   done,
  output logic                   fail,
  output logic [7:0]             final_status,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_chip_select_n,
  output logic                   flash_output_enable_n,
  output logic                   flash_write_strobe_n
);

  localparam int TMR_W  = $clog2(ERASE_TIMER_CYCLES + 1);
  localparam int POLL_W = $clog2(POLL_LIMIT + 1);
  localparam logic [TMR_W-1:0]  TMR_END  = TMR_W'(ERASE_TIMER_CYCLES);
  localparam logic [POLL_W-1:0] POLL_END = POLL_W'(POLL_LIMIT);

  poll_state_t         state_reg;
  poll_state_t         state_next;
  logic                issued_reg;
  logic                req_reg;
  logic                req_write_reg;
  logic                erase_reg;
  logic                exp7_reg;
  logic                fail_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic [7:0]          first_reg;
  logic [TMR_W-1:0]    tmr_reg;
  logic [POLL_W-1:0]   poll_reg;
  logic                ack;
  logic [DATA_W-1:0]   rdata;

  // Reserved bits 0, 1 and 4 never reach any decision
  wire logic [7:0] rd_masked  = rdata[7:0] & `STATUS_MASK;
  // Finished when bit 6 stops toggling between two successive reads
  wire logic       toggling   = first_reg[`DQ_TOGGLE_BIT] ^ rd_masked[`DQ_TOGGLE_BIT];
  wire logic       err_seen   = rd_masked[`DQ_ERROR_BIT];
  wire logic       timer_open = ~rd_masked[`DQ_ETIMER_BIT];
  wire logic       tmr_over   = (tmr_reg == TMR_END);
  wire logic       poll_over  = (poll_reg == POLL_END);
  wire logic       want7      = erase_reg ? 1'b1 : exp7_reg;
  wire logic       final_ok   = (rd_masked[`DQ_POLL_BIT] == want7) & ~err_seen;
  wire logic       read_step  = issued_reg & ack;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = op_is_erase ? ST_TIMER_READ : ST_READ_A;
        end
      end
      ST_TIMER_READ: begin
        // Erase has not started while the timer bit still reads low
        if (read_step) begin
          if (!timer_open) begin
            state_next = ST_READ_A;
          end else if (tmr_over) begin
            state_next = ST_RESET_CMD;
          end
        end
      end
      ST_READ_A: begin
        if (read_step) begin
          state_next = ST_READ_B;
        end
      end
      ST_READ_B: begin
        if (read_step) begin
          if (!toggling) begin
            state_next = ST_FINAL;
          end else if (err_seen) begin
            state_next = ST_ERR_A;
          end else if (poll_over) begin
            state_next = ST_RESET_CMD;
          end else begin
            state_next = ST_READ_A;
          end
        end
      end
      ST_ERR_A: begin
        if (read_step) begin
          state_next = ST_ERR_B;
        end
      end
      ST_ERR_B: begin
        if (read_step) begin
          state_next = toggling ? ST_RESET_CMD : ST_FINAL;
        end
      end
      ST_FINAL: begin
        if (read_step) begin
          state_next = final_ok ? ST_DONE : ST_RESET_CMD;
        end
      end
      ST_RESET_CMD: begin
        if (read_step) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire logic bus_state = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
  wire logic to_fail   = read_step && (state_next == ST_RESET_CMD) &&
                         (state_reg != ST_RESET_CMD);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_IDLE;
      issued_reg    <= 1'b0;
      req_reg       <= 1'b0;
      req_write_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      req_reg       <= 1'b0;
      if (bus_state && !issued_reg && !req_reg) begin
        req_reg       <= 1'b1;
        issued_reg    <= 1'b1;
        req_write_reg <= (state_reg == ST_RESET_CMD);
      end else if (read_step) begin
        issued_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_reg <= 1'b0;
      exp7_reg  <= 1'b0;
      addr_reg  <= '0;
      first_reg <= 8'h00;
      tmr_reg   <= '0;
      poll_reg  <= '0;
    end else if (state_reg == ST_IDLE) begin
      // Poll address is the programmed word or a word inside the erased block
      erase_reg <= op_is_erase;
      exp7_reg  <= expected_dq7;
      addr_reg  <= poll_addr;
      tmr_reg   <= '0;
      poll_reg  <= '0;
    end else begin
      if (!tmr_over) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
      if (read_step && (state_reg == ST_READ_A || state_reg == ST_ERR_A)) begin
        first_reg <= rd_masked;
      end
      if (read_step && state_reg == ST_READ_B && !poll_over) begin
        poll_reg <= poll_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_reg     <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      fail         <= 1'b0;
      final_status <= 8'h00;
    end else begin
      done <= (state_reg == ST_DONE);
      busy <= (state_next != ST_IDLE);
      if (state_reg == ST_IDLE && start) begin
        fail_reg <= 1'b0;
      end else if (to_fail) begin
        // Error stays latched on the flash until the read/reset write goes out
        fail_reg <= 1'b1;
      end
      if (read_step && state_reg != ST_RESET_CMD) begin
        final_status <= rd_masked;
      end
      if (state_reg == ST_DONE) begin
        fail <= fail_reg;
      end
    end
  end

  flash_bus_cycle #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_cycle (
    .clk                   (clk),
    .nrst                  (nrst),
    .req                   (req_reg),
    .req_write             (req_write_reg),
    .req_addr              (addr_reg),
    .req_wdata             (DATA_W'(READ_RESET_DATA)),
    .ack                   (ack),
    .rdata                 (rdata),
    .flash_addr            (flash_addr),
    .flash_dq_out          (flash_dq_out),
    .flash_dq_oe           (flash_dq_oe),
    .flash_dq_in           (flash_dq_in),
    .flash_chip_select_n   (flash_chip_select_n),
    .flash_output_enable_n (flash_output_enable_n),
    .flash_write_strobe_n  (flash_write_strobe_n)
  );

endmodule

//--- flash_program_erase_status_properties.sv
// Port checks for the flash status poller
`timescale 1ns/1ps
module flash_program_erase_status_properties #(
  parameter int          ADDR_W          = 21,
  parameter int          DATA_W          = 16,
  parameter logic [15:0] READ_RESET_DATA = 16'h00f0
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // User port
  input wire logic              start,
  input wire logic              op_is_erase,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              fail,
  input wire logic [7:0]        final_status,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_chip_select_n,
  input wire logic              flash_output_enable_n,
  input wire logic              flash_write_strobe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reserved_bits_masked: assert property (
    final_status[4] == 1'b0 && final_status[1:0] == 2'b00)
    else $error("reserved bits not masked");
  a_no_bus_fight: assert property (flash_dq_oe |-> flash_output_enable_n)
    else $error("host drives bus during read");
  a_reset_word: assert property (
    !flash_write_strobe_n |-> flash_dq_oe && flash_dq_out == READ_RESET_DATA)
    else $error("bad reset write");
  a_write_ends_failed: assert property (
    $rose(flash_write_strobe_n) |-> ##[1:20] (done && fail))
    else $error("reset write without fail");
  a_read_pulse_width: assert property (
    $fell(flash_output_enable_n) |-> !flash_output_enable_n[*6] ##1 flash_output_enable_n)
    else $error("read pulse width");
  a_poll_addr_held: assert property (
    !flash_chip_select_n && !$past(flash_chip_select_n) |-> $stable(flash_addr))
    else $error("address moved in access");
  a_select_with_strobe: assert property (
    !(flash_output_enable_n && flash_write_strobe_n) |-> !flash_chip_select_n)
    else $error("strobe without select");
  a_done_single: assert property (done |=> !done && !busy)
    else $error("done not a pulse");
  a_start_sets_busy: assert property (start && !busy && !done |=> busy)
    else $error("start not taken");
  c_pass: cover property (done && !fail);
  c_fail: cover property (done && fail);
  c_erase: cover property (start && op_is_erase && !busy);
endmodule
bind flash_program_erase_status flash_program_erase_status_properties #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W), .READ_RESET_DATA(READ_RESET_DATA)
) chk (
  .clk(clk), .nrst(nrst), .start(start), .op_is_erase(op_is_erase), .busy(busy),
  .done(done), .fail(fail), .final_status(final_status), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_chip_select_n(flash_chip_select_n), .flash_output_enable_n(flash_output_enable_n),
  .flash_write_strobe_n(flash_write_strobe_n)
);

//--- flash_dev_model.sv
// Behavioural flash device answering status polls
`timescale 1ns/1ps
module flash_dev_model (
  // Flash pins
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  output logic      [15:0] flash_dq_in,
  input  wire logic        flash_chip_select_n,
  input  wire logic        flash_output_enable_n,
  input  wire logic        flash_write_strobe_n
);
  logic        erase_op   = 1'b0;
  logic        data7      = 1'b0;
  logic        err        = 1'b0;
  logic        tog        = 1'b0;
  logic        susp       = 1'b0;
  int          susp_in    = 0;
  int          busy_left  = 0;
  int          timer_left = 0;
  int          resets     = 0;
  logic [15:0] last       = 16'h0000;
  logic [7:0]  status;
  wire         busy = (busy_left > 0) || (timer_left > 0);
  wire         rd_n = flash_chip_select_n | flash_output_enable_n;
  wire         wr_n = flash_chip_select_n | flash_write_strobe_n;
  // Address bit 20 picks the bank; bank 0 is the one being modified
  wire         own_bank = !flash_addr[20];
  // Polls always land in the erased block, so a suspend shows that block's values
  wire         sus_blk = susp & erase_op;
  wire  [15:0] word    = own_bank ? {8'h5a, status} : 16'h5a4c;
  // A program during suspend shows normal status bits, but its busy count still stops
  assign status[7] = (busy & !sus_blk) ? (!erase_op & ~data7)
                                       : (erase_op | data7);
  assign status[6] = sus_blk ? 1'b1 : (busy ? tog : 1'b1);
  assign status[5] = err;
  assign status[4] = 1'b1;
  assign status[3] = !(erase_op && timer_left > 0);
  assign status[2] = sus_blk ? tog
                   : (busy ? !erase_op : (erase_op & err ? tog : 1'b1));
  // Reserved bits kept high so an unmasking host is caught
  assign status[1:0] = 2'b11;
  // Released bus shows the inverse of the last word, never stale data
  assign flash_dq_in = !rd_n ? word : ~last;
  task automatic arm(input logic e, input logic d7, input logic er, input int nb, input int nt);
    erase_op = e;
    data7 = d7;
    err = er;
    busy_left = nb;
    timer_left = nt;
    susp = 1'b0;
  endtask
  always @(posedge rd_n) begin
    last = word;
    tog = ~tog;
    if (susp_in == 1) susp = 1'b1;
    if (susp_in > 0) susp_in--;
    if (timer_left > 0) timer_left--;
    else if (busy_left > 0 && !susp) busy_left--;
  end
  always @(posedge wr_n) begin
    if (flash_dq_oe && flash_dq_out == 16'h00f0) begin
      err = 1'b0;
      busy_left = 0;
      timer_left = 0;
      resets++;
    end
  end
endmodule

//--- test_flash_program_erase_status.sv
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module test_flash_program_erase_status;
  import flash_status_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, start = 1'b0, op_is_erase = 1'b0, expected_dq7 = 1'b0;
  logic [20:0] poll_addr = 21'h012345;
  logic        busy, done, fail, flash_dq_oe, cs_n, oe_n, we_n;
  logic [7:0]  final_status;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in;
  int          errors = 0, num_checks = 0;
  always #10 clk = ~clk;
  // Short counts keep the timeout cases quick
  flash_program_erase_status #(.ERASE_TIMER_CYCLES(200), .POLL_LIMIT(8)) uut (
    .clk(clk), .nrst(nrst), .start(start), .op_is_erase(op_is_erase), .poll_addr(poll_addr),
    .expected_dq7(expected_dq7), .busy(busy), .done(done), .fail(fail),
    .final_status(final_status), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_chip_select_n(cs_n),
    .flash_output_enable_n(oe_n), .flash_write_strobe_n(we_n));
  flash_dev_model dev (
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_chip_select_n(cs_n), .flash_output_enable_n(oe_n), .flash_write_strobe_n(we_n));
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One poll; start stays high for three cycles, two of them into busy, and must not be taken twice
  task automatic run(input logic e, input logic x7, input logic d7, input logic er,
                     input int nb, input int nt, input logic xf, input logic [7:0] xs);
    int n;
    int r0;
    r0 = dev.resets;
    dev.arm(e, d7, er, nb, nt);
    @(negedge clk);
    op_is_erase = e;
    expected_dq7 = x7;
    start = 1'b1;
    repeat (3) @(negedge clk);
    start = 1'b0;
    check_byte({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      errors++;
      $display("Error at %0t: no done", $time);
      give_verdict;
    end else begin
      check_byte({7'h00, fail}, {7'h00, xf});
      check_byte({7'h00, dev.resets != r0}, {7'h00, xf});
      check_byte({7'h00, flash_addr === poll_addr}, 8'h01);
      if (xs !== 8'h00) check_byte(final_status, xs);
      check_byte({7'h00, dev.err}, 8'h00);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    run(1'b0, 1'b1, 1'b1, 1'b0, 3, 0, 1'b0, 8'hcc);
    run(1'b0, 1'b0, 1'b0, 1'b0, 0, 0, 1'b0, 8'h4c);
    run(1'b1, 1'b0, 1'b0, 1'b0, 4, 3, 1'b0, 8'hcc);
    run(1'b0, 1'b1, 1'b0, 1'b0, 2, 0, 1'b1, 8'h4c);
    run(1'b0, 1'b1, 1'b1, 1'b1, 999, 0, 1'b1, 8'h00);
    run(1'b0, 1'b1, 1'b1, 1'b0, 999, 0, 1'b1, 8'h00);
    run(1'b1, 1'b0, 1'b0, 1'b0, 0, 999, 1'b1, 8'h00);
    // Suspend arrives after the third read; bit 2 keeps toggling so it is left out
    dev.susp_in = 3;
    run(1'b1, 1'b0, 1'b0, 1'b0, 999, 0, 1'b0, 8'h00);
    check_byte({final_status[7:3], 3'b000}, 8'hc8);
    poll_addr = 21'h112345;
    run(1'b0, 1'b0, 1'b1, 1'b0, 999, 0, 1'b0, 8'h4c);
    give_verdict;
  end
endmodule
